//--- rtl/twm_pkg.sv
// package for the timer16 waveform-mode control block
package twm_pkg;
  localparam int         APB_AW         = 8;
  localparam logic [7:0] OFS_CONTROL_A  = 8'h00;
  localparam logic [7:0] OFS_CONTROL_B  = 8'h04;
  localparam logic [7:0] OFS_PIN_DIR    = 8'h08;
  localparam logic [7:0] OFS_STATUS     = 8'h0C;
  localparam logic [7:0] RST_CONTROL_A  = 8'h00;
  localparam logic [7:0] RST_CONTROL_B  = 8'h00;
  localparam logic [1:0] RST_PIN_DIR    = 2'h0;
  // control A field positions
  localparam int         CA_CMP_A_HI    = 7;
  localparam int         CA_CMP_A_LO    = 6;
  localparam int         CA_CMP_B_HI    = 5;
  localparam int         CA_CMP_B_LO    = 4;
  localparam int         CA_FORCE_A     = 3;
  localparam int         CA_FORCE_B     = 2;
  localparam int         CA_WAVE_HI     = 1;
  localparam int         CA_WAVE_LO     = 0;
  // control B field positions
  localparam int         CB_WAVE_HI     = 4;
  localparam int         CB_WAVE_LO     = 3;
  localparam logic [7:0] CB_WMASK       = 8'h18;
  // fixed tops, bottom value and named mode codes
  localparam logic [15:0] TOP_MAX       = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT      = 16'h00FF;
  localparam logic [15:0] TOP_9BIT      = 16'h01FF;
  localparam logic [15:0] TOP_10BIT     = 16'h03FF;
  localparam logic [15:0] BOTTOM_VAL    = 16'h0000;
  localparam logic [3:0] MODE_CTC_CMPA  = 4'hF & 4'h4;
  localparam logic [3:0] MODE_FAST_CMPA = 4'hF;
  localparam logic [3:0] MODE_PFC_CMPA  = 4'h9;
  localparam logic [3:0] MODE_TGL_ALT   = 4'hE;

  typedef enum logic [1:0] {
    WC_NORMAL = 2'b00,
    WC_FAST   = 2'b01,
    WC_DUAL   = 2'b10
  } twm_class_type;

  typedef enum logic [1:0] {
    TS_FIXED  = 2'b00,
    TS_CMP_A  = 2'b01,
    TS_CAPT   = 2'b10
  } twm_topsrc_type;

  typedef enum logic [1:0] {
    PT_IMMED  = 2'b00,
    PT_TOP    = 2'b01,
    PT_BOTTOM = 2'b10,
    PT_MAX    = 2'b11
  } twm_point_type;

  typedef struct packed {
    twm_class_type  wclass;
    twm_topsrc_type top_src;
    logic [15:0]    top_fixed;
    twm_point_type  update_pt;
    twm_point_type  ovf_pt;
  } twm_mode_type;

  // counter-side events presented to the waveform logic
  typedef struct packed {
    logic match_a;
    logic match_b;
    logic at_top;
    logic count_up;
    logic cmp_a_eq_top;
    logic cmp_b_eq_top;
  } twm_event_type;
endpackage

//--- rtl/twm_wave_ctrl.sv
// control registers A and B of the 16-bit timer with waveform-mode decode and compare outputs
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module twm_wave_ctrl
  import twm_pkg::*;
(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [APB_AW-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic                     pready,
  output logic [31:0]              prdata,
  output logic                     pslverr,
  input  wire twm_event_type       events,
  output twm_mode_type             mode_decode,
  output logic [3:0]               wave_mode_sel,
  output logic                     wave_out_a,
  output logic                     wave_out_b,
  output logic                     pin_override_a,
  output logic                     pin_override_b,
  output logic                     pin_oe_n_a,
  output logic                     pin_oe_n_b,
  output logic                     match_flag_a,
  output logic                     match_flag_b,
  output logic                     clear_on_match_req
);

  // helpers
  function automatic twm_mode_type decode_mode(input logic [3:0] m);
    twm_mode_type d;
    d = '{WC_NORMAL, TS_FIXED, TOP_MAX, PT_IMMED, PT_MAX};
    unique case (m)
      4'h1: d = '{WC_DUAL, TS_FIXED, TOP_8BIT,  PT_TOP, PT_BOTTOM};
      4'h2: d = '{WC_DUAL, TS_FIXED, TOP_9BIT,  PT_TOP, PT_BOTTOM};
      4'h3: d = '{WC_DUAL, TS_FIXED, TOP_10BIT, PT_TOP, PT_BOTTOM};
      4'h4: d = '{WC_NORMAL, TS_CMP_A, TOP_MAX, PT_IMMED, PT_MAX};
      4'h5: d = '{WC_FAST, TS_FIXED, TOP_8BIT,  PT_TOP, PT_TOP};
      4'h6: d = '{WC_FAST, TS_FIXED, TOP_9BIT,  PT_TOP, PT_TOP};
      4'h7: d = '{WC_FAST, TS_FIXED, TOP_10BIT, PT_TOP, PT_TOP};
      4'h8: d = '{WC_DUAL, TS_CAPT,  TOP_MAX, PT_BOTTOM, PT_BOTTOM};
      4'h9: d = '{WC_DUAL, TS_CMP_A, TOP_MAX, PT_BOTTOM, PT_BOTTOM};
      4'hA: d = '{WC_DUAL, TS_CAPT,  TOP_MAX, PT_TOP, PT_BOTTOM};
      4'hB: d = '{WC_DUAL, TS_CMP_A, TOP_MAX, PT_TOP, PT_BOTTOM};
      4'hC: d = '{WC_NORMAL, TS_CAPT, TOP_MAX, PT_IMMED, PT_MAX};
      4'hE: d = '{WC_FAST, TS_CAPT,  TOP_MAX, PT_TOP, PT_TOP};
      4'hF: d = '{WC_FAST, TS_CMP_A, TOP_MAX, PT_TOP, PT_TOP};
      default: d = '{WC_NORMAL, TS_FIXED, TOP_MAX, PT_IMMED, PT_MAX}; // 0 and reserved 13
    endcase
    return d;
  endfunction

  // in the PWM modes, toggle setting 01 drives channel A only, and only in modes 9 and F
  function automatic logic connected(input logic [1:0] com, input twm_class_type c,
                                     input logic [3:0] m, input logic chan_a);
    logic ok;
    ok = (com != 2'b00);
    if (com == 2'b01 && c == WC_FAST)
      ok = chan_a && (m == MODE_FAST_CMPA);
    if (com == 2'b01 && c == WC_DUAL)
      ok = chan_a && (m == MODE_PFC_CMPA || m == MODE_TGL_ALT);
    return ok;
  endfunction

  function automatic logic wave_next(input logic cur, input logic [1:0] com,
                                     input twm_class_type c, input logic conn,
                                     input logic match, input logic force_m,
                                     input logic at_top, input logic up,
                                     input logic eq_top);
    logic n;
    n = cur;
    if (conn) begin
      unique case (c)
        WC_NORMAL: begin
          if (match || force_m) begin
            n = com[1] ? com[0] : ~cur;
          end
        end
        WC_FAST: begin
          if (com[1] && at_top) begin
            n = ~com[0];
          end else if (match && !(com[1] && eq_top)) begin
            n = com[1] ? com[0] : ~cur;
          end
        end
        WC_DUAL: begin
          if (match) begin
            n = com[1] ? (up ? com[0] : ~com[0]) : ~cur;
          end
        end
        default: n = cur;
      endcase
    end
    return n;
  endfunction

  // registers
  logic [7:0] control_a_reg;
  logic [7:0] control_b_reg;
  logic [1:0] pin_dir_reg;
  logic       force_a_reg;
  logic       force_b_reg;
  logic       pready_reg;
  logic [31:0] prdata_reg;
  logic       pslverr_reg;
  logic       wave_a_reg;
  logic       wave_b_reg;
  logic       ovr_a_reg;
  logic       ovr_b_reg;
  logic       oe_n_a_reg;
  logic       oe_n_b_reg;
  logic       flag_a_reg;
  logic       flag_b_reg;
  logic       ctc_clr_reg;
  twm_mode_type mode_reg;
  logic [3:0] mode_sel_reg;

  // decode
  wire logic [3:0] mode_cur = {control_b_reg[CB_WAVE_HI:CB_WAVE_LO],
                               control_a_reg[CA_WAVE_HI:CA_WAVE_LO]};
  wire twm_mode_type dec_cur = decode_mode(mode_cur);
  wire logic [1:0] com_a = control_a_reg[CA_CMP_A_HI:CA_CMP_A_LO];
  wire logic [1:0] com_b = control_a_reg[CA_CMP_B_HI:CA_CMP_B_LO];
  wire logic conn_a = connected(com_a, dec_cur.wclass, mode_cur, 1'b1);
  wire logic conn_b = connected(com_b, dec_cur.wclass, mode_cur, 1'b0);
  // a forced match only exists in the non-PWM modes
  wire logic frc_a = force_a_reg && dec_cur.wclass == WC_NORMAL;
  wire logic frc_b = force_b_reg && dec_cur.wclass == WC_NORMAL;
  wire logic wave_a_next = wave_next(wave_a_reg, com_a, dec_cur.wclass, conn_a,
                                     events.match_a, frc_a, events.at_top,
                                     events.count_up, events.cmp_a_eq_top);
  wire logic wave_b_next = wave_next(wave_b_reg, com_b, dec_cur.wclass, conn_b,
                                     events.match_b, frc_b, events.at_top,
                                     events.count_up, events.cmp_b_eq_top);

  // bus decode: one wait state, answer registered
  wire logic acc_phase = psel && penable && !pready_reg;
  wire logic wr_done   = psel && penable && pready_reg && pwrite;
  wire logic sel_a     = paddr == OFS_CONTROL_A;
  wire logic sel_b     = paddr == OFS_CONTROL_B;
  wire logic sel_dir   = paddr == OFS_PIN_DIR;
  wire logic sel_st    = paddr == OFS_STATUS;
  wire logic mapped    = sel_a || sel_b || sel_dir || sel_st;
  wire logic wr_a      = wr_done && sel_a && pstrb[0];
  wire logic wr_b      = wr_done && sel_b && pstrb[0];
  wire logic wr_dir    = wr_done && sel_dir && pstrb[0];
  wire logic [7:0] ca_store = pwdata[7:0] & 8'hF3; // strobe bits never stored
  wire logic [31:0] status_word = {22'h0, dec_cur.top_src, 2'h0, dec_cur.wclass,
                                   ovr_b_reg, ovr_a_reg, wave_b_reg, wave_a_reg};
  wire logic [31:0] rd_word = sel_a   ? {24'h0, control_a_reg} :
                              sel_b   ? {24'h0, control_b_reg} :
                              sel_dir ? {30'h0, pin_dir_reg} :
                              sel_st  ? status_word : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= acc_phase;
      prdata_reg  <= (acc_phase && !pwrite) ? rd_word : 32'h0;
      pslverr_reg <= acc_phase && !mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_a_reg <= RST_CONTROL_A;
      control_b_reg <= RST_CONTROL_B;
      pin_dir_reg   <= RST_PIN_DIR;
      force_a_reg   <= 1'b0;
      force_b_reg   <= 1'b0;
    end else begin
      if (wr_a) control_a_reg <= ca_store;
      if (wr_b) control_b_reg <= pwdata[7:0] & CB_WMASK;
      if (wr_dir) pin_dir_reg <= pwdata[1:0];
      force_a_reg <= wr_a && pwdata[CA_FORCE_A];
      force_b_reg <= wr_a && pwdata[CA_FORCE_B];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wave_a_reg   <= 1'b0;
      wave_b_reg   <= 1'b0;
      ovr_a_reg    <= 1'b0;
      ovr_b_reg    <= 1'b0;
      oe_n_a_reg   <= 1'b1;
      oe_n_b_reg   <= 1'b1;
      flag_a_reg   <= 1'b0;
      flag_b_reg   <= 1'b0;
      ctc_clr_reg  <= 1'b0;
      mode_reg     <= '{WC_NORMAL, TS_FIXED, TOP_MAX, PT_IMMED, PT_MAX};
      mode_sel_reg <= 4'h0;
    end else begin
      wave_a_reg   <= wave_a_next;
      wave_b_reg   <= wave_b_next;
      ovr_a_reg    <= conn_a;
      ovr_b_reg    <= conn_b;
      oe_n_a_reg   <= !(conn_a && pin_dir_reg[0]);
      oe_n_b_reg   <= !(conn_b && pin_dir_reg[1]);
      // flags and counter clear follow real matches only
      flag_a_reg   <= events.match_a;
      flag_b_reg   <= events.match_b;
      ctc_clr_reg  <= events.match_a && mode_cur == MODE_CTC_CMPA;
      mode_reg     <= dec_cur;
      mode_sel_reg <= mode_cur;
    end
  end

  assign pready             = pready_reg;
  assign prdata             = prdata_reg;
  assign pslverr            = pslverr_reg;
  assign mode_decode        = mode_reg;
  assign wave_mode_sel      = mode_sel_reg;
  assign wave_out_a         = wave_a_reg;
  assign wave_out_b         = wave_b_reg;
  assign pin_override_a     = ovr_a_reg;
  assign pin_override_b     = ovr_b_reg;
  assign pin_oe_n_a         = oe_n_a_reg;
  assign pin_oe_n_b         = oe_n_b_reg;
  assign match_flag_a       = flag_a_reg;
  assign match_flag_b       = flag_b_reg;
  assign clear_on_match_req = ctc_clr_reg;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_strobe_read_zero: assert property (
    (psel && penable && pready_reg && !pwrite && sel_a) |-> prdata_reg[3:2] == 2'b00)
    else $error("force strobes read back nonzero");
  chk_idle_no_override: assert property (
    (com_a == 2'b00) |=> !pin_override_a)
    else $error("channel A override with mode field zero");
  chk_drive_needs_dir: assert property (
    !pin_oe_n_a |-> $past(pin_dir_reg[0]) && pin_override_a)
    else $error("channel A driven without output direction");
  chk_nonpwm_set: assert property (
    (dec_cur.wclass == WC_NORMAL && com_a == 2'b11 && events.match_a) |=> wave_out_a)
    else $error("set on match failed in non-PWM mode");
  chk_fast_top_set: assert property (
    (dec_cur.wclass == WC_FAST && com_a == 2'b10 && events.at_top) |=> wave_out_a)
    else $error("fast PWM did not set at top");
  chk_fast_toggle_gate: assert property (
    (dec_cur.wclass == WC_FAST && com_b == 2'b01) |=> !pin_override_b)
    else $error("channel B connected under fast toggle");
  chk_eq_top_ignore: assert property (
    (dec_cur.wclass == WC_FAST && com_a[1] && events.cmp_a_eq_top && !events.at_top)
    |=> wave_out_a == $past(wave_out_a))
    else $error("match at top not ignored");
  chk_dual_up_clear: assert property (
    (dec_cur.wclass == WC_DUAL && com_a == 2'b10 && events.match_a && events.count_up)
    |=> !wave_out_a)
    else $error("dual slope up match did not clear");
  chk_force_pwm_ignored: assert property (
    (wr_a && pwdata[CA_FORCE_A] && pwdata[CA_WAVE_HI:CA_WAVE_LO] != 2'b00
     && control_b_reg[CB_WAVE_HI:CB_WAVE_LO] == 2'b00 && !events.match_a && !events.at_top)
    ##1 (!events.match_a && !events.at_top) |=> wave_out_a == $past(wave_out_a, 2))
    else $error("force acted in a PWM mode");
  chk_force_no_flag: assert property (
    (force_a_reg && !events.match_a) |=> !match_flag_a && !clear_on_match_req)
    else $error("forced match raised a flag or clear");
  chk_normal_top: assert property (
    (mode_cur == 4'h0) |=> mode_decode.top_fixed == TOP_MAX && mode_decode.ovf_pt == PT_MAX)
    else $error("normal mode top wrong");

  cov_force_toggle: cover property (frc_a && com_a == 2'b01 ##1 wave_out_a != $past(wave_out_a));
  cov_fast_cycle: cover property (dec_cur.wclass == WC_FAST && events.at_top && conn_a);
  cov_dual_down: cover property (dec_cur.wclass == WC_DUAL && events.match_b && !events.count_up);

endmodule // twm_wave_ctrl
`default_nettype wire

//--- testbench/twm_pin_model.sv
// port pin model driven by the two waveform outputs, pads pulled up
`timescale 1ns/1ps
`default_nettype none
module twm_pin_model (
  input  wire logic wave_a,
  input  wire logic wave_b,
  input  wire logic oe_n_a,
  input  wire logic oe_n_b,
  output logic      pin_a,
  output logic      pin_b
);
  // released pad floats to the pull-up, never the last driven level
  assign pin_a = oe_n_a ? 1'b1 : wave_a;
  assign pin_b = oe_n_b ? 1'b1 : wave_b;
endmodule // twm_pin_model
`default_nettype wire

//--- testbench/tb.sv
// self-checking bench for the timer16 waveform-mode control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import twm_pkg::*;
  logic          pclk = 0;
  logic          presetn = 0;
  logic          psel = 0;
  logic          penable = 0;
  logic          pwrite = 0;
  logic [7:0]    paddr = 0;
  logic [31:0]   pwdata = 0;
  logic [3:0]    pstrb = 4'hF;
  logic          pready, pslverr, wave_out_a, wave_out_b, pin_a, pin_b;
  logic          pin_override_a, pin_override_b, pin_oe_n_a, pin_oe_n_b;
  logic          match_flag_a, match_flag_b, clear_on_match_req;
  logic [31:0]   prdata;
  logic [3:0]    wave_mode_sel;
  twm_mode_type  mode_decode;
  twm_event_type ev = '0;
  logic          eqt = 0;
  logic [33:0]   exp_q[$];
  logic [33:0]   e;
  logic [31:0]   r;
  logic [15:0]   ef;
  twm_class_type  ec;
  twm_topsrc_type es;
  twm_point_type  ep, eo;
  int            err_total = 0;
  int            cmp_count = 0;

  always #2 pclk = ~pclk;

  twm_wave_ctrl u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .events(ev), .mode_decode(mode_decode), .wave_mode_sel(wave_mode_sel),
    .wave_out_a(wave_out_a), .wave_out_b(wave_out_b), .pin_override_a(pin_override_a),
    .pin_override_b(pin_override_b), .pin_oe_n_a(pin_oe_n_a), .pin_oe_n_b(pin_oe_n_b),
    .match_flag_a(match_flag_a), .match_flag_b(match_flag_b),
    .clear_on_match_req(clear_on_match_req));

  twm_pin_model u_pins (
    .wave_a(wave_out_a), .wave_b(wave_out_b), .oe_n_a(pin_oe_n_a), .oe_n_b(pin_oe_n_b),
    .pin_a(pin_a), .pin_b(pin_b));

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // one transfer; the note goes on the queue before the request starts
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] x);
    int n;
    exp_q.push_back({wr, x});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
      tally_and_finish();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, {1'b0, x});
  endtask

  // mode high bits first so a force strobe is judged against the new mode
  // callers keep strobes zero in pwm modes, bar one deliberate probe
  task automatic sm(input logic [3:0] m, input logic [1:0] ca, cb, f);
    wr(OFS_CONTROL_B, {27'h0, m[3:2], 3'h0});
    wr(OFS_CONTROL_A, {24'h0, ca, cb, f, m[1:0]});
    repeat (2) @(posedge pclk);
    #1;
  endtask

  task automatic pulse(input logic ma, mb, top, up);
    @(posedge pclk);
    ev <= '{ma, mb, top, up, eqt, 1'b0};
    @(posedge pclk);
    ev <= '{1'b0, 1'b0, 1'b0, up, eqt, 1'b0};
    #1;
  endtask

  always @(posedge pclk) begin
    if (pready === 1'b1) begin
      e = exp_q.pop_front();
      chk({31'h0, pslverr}, {31'h0, e[32]});
      if (!e[33]) chk(prdata, e[31:0]);
    end
  end

  initial begin
    r = $urandom(32'h9359);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk({31'h0, pin_oe_n_a}, 32'h1);
    chk({30'h0, mode_decode.wclass}, 32'h0);
    rd(OFS_CONTROL_A, 32'h0);
    r = $urandom;
    wr(OFS_CONTROL_B, r);
    rd(OFS_CONTROL_B, r & 32'h18);
    apb(1'b0, 8'h10, 32'h0, {1'b1, 32'h0});
    $display("test registers done");
    for (int m = 0; m < 16; m++) begin
      sm(4'(m), 2'b00, 2'b00, 2'b00);
      case (m)
        0, 4, 12, 13: begin ec = WC_NORMAL; ep = PT_IMMED; eo = PT_MAX; end
        5, 6, 7, 14, 15: begin ec = WC_FAST; ep = PT_TOP; eo = PT_TOP; end
        8, 9: begin ec = WC_DUAL; ep = PT_BOTTOM; eo = PT_BOTTOM; end
        default: begin ec = WC_DUAL; ep = PT_TOP; eo = PT_BOTTOM; end
      endcase
      es = (m inside {4, 9, 11, 15}) ? TS_CMP_A : (m inside {8, 10, 12, 14}) ? TS_CAPT : TS_FIXED;
      ef = (m > 7 || m % 4 == 0) ? TOP_MAX : (m % 4 == 1) ? TOP_8BIT
         : (m % 4 == 2) ? TOP_9BIT : TOP_10BIT;
      chk({28'h0, wave_mode_sel}, m);
      chk({30'h0, mode_decode.wclass}, {30'h0, ec});
      chk({30'h0, mode_decode.top_src}, {30'h0, es});
      chk({30'h0, mode_decode.update_pt}, {30'h0, ep});
      chk({30'h0, mode_decode.ovf_pt}, {30'h0, eo});
      if (es == TS_FIXED) chk({16'h0, mode_decode.top_fixed}, {16'h0, ef});
    end
    $display("test mode decode done");
    wr(OFS_PIN_DIR, 32'h3);
    sm(4'h0, 2'b01, 2'b11, 2'b00);
    chk({31'h0, pin_override_a}, 32'h1);
    pulse(1'b1, 1'b1, 1'b0, 1'b1);
    chk({30'h0, wave_out_a, wave_out_b}, 32'h3);
    chk({31'h0, match_flag_a}, 32'h1);
    chk({31'h0, match_flag_b}, 32'h1);
    chk({30'h0, pin_oe_n_b, pin_b}, 32'h1);
    sm(4'h0, 2'b10, 2'b00, 2'b00);
    pulse(1'b1, 1'b0, 1'b0, 1'b1);
    chk({31'h0, pin_a}, 32'h0);
    chk({31'h0, pin_override_b}, 32'h0);
    wr(OFS_PIN_DIR, 32'h0);
    repeat (2) @(posedge pclk);
    #1;
    chk({30'h0, pin_oe_n_a, pin_a}, 32'h3);
    $display("test normal mode done");
    // force with set action in clear-on-match mode: no flag, no counter clear
    // looked at one edge after the strobe, while a wrong flag would still stand
    wr(OFS_CONTROL_B, 32'h08);
    wr(OFS_CONTROL_A, 32'hC8);
    @(posedge pclk);
    #1;
    chk({31'h0, wave_out_a}, 32'h1);
    chk({30'h0, match_flag_a, clear_on_match_req}, 32'h0);
    @(posedge pclk);
    #1;
    chk({30'h0, match_flag_a, clear_on_match_req}, 32'h0);
    rd(OFS_CONTROL_A, 32'hC0);
    // strobe written in a pwm mode on purpose: it must do nothing
    sm(4'h5, 2'b10, 2'b00, 2'b10);
    chk({31'h0, wave_out_a}, 32'h1);
    pulse(1'b1, 1'b0, 1'b0, 1'b1);
    chk({31'h0, wave_out_a}, 32'h0);
    pulse(1'b0, 1'b0, 1'b1, 1'b1);
    chk({31'h0, wave_out_a}, 32'h1);
    eqt = 1'b1;
    pulse(1'b1, 1'b0, 1'b0, 1'b1);
    chk({31'h0, wave_out_a}, 32'h1);
    eqt = 1'b0;
    sm(4'h5, 2'b11, 2'b00, 2'b00);
    pulse(1'b0, 1'b0, 1'b1, 1'b1);
    chk({31'h0, wave_out_a}, 32'h0);
    pulse(1'b1, 1'b0, 1'b0, 1'b1);
    chk({31'h0, wave_out_a}, 32'h1);
    $display("test fast pwm done");
    for (int c = 2; c < 4; c++) begin
      sm(4'h1, 2'(c), 2'b00, 2'b00);
      pulse(1'b1, 1'b0, 1'b0, 1'b1);
      chk({31'h0, wave_out_a}, c - 2);
      pulse(1'b1, 1'b0, 1'b0, 1'b0);
      chk({31'h0, wave_out_a}, 3 - c);
    end
    $display("test dual slope done");
    sm(4'hF, 2'b10, 2'b00, 2'b00);
    pulse(1'b0, 1'b0, 1'b1, 1'b1);
    sm(4'hF, 2'b01, 2'b01, 2'b00);
    chk({30'h0, pin_override_a, pin_override_b}, 32'h2);
    pulse(1'b1, 1'b1, 1'b0, 1'b1);
    chk({31'h0, wave_out_a}, 32'h0);
    sm(4'hE, 2'b01, 2'b01, 2'b00);
    chk({30'h0, pin_override_a, pin_override_b}, 32'h0);
    sm(4'h9, 2'b01, 2'b01, 2'b00);
    chk({30'h0, pin_override_a, pin_override_b}, 32'h2);
    pulse(1'b1, 1'b0, 1'b0, 1'b1);
    chk({31'h0, wave_out_a}, 32'h1);
    sm(4'hB, 2'b01, 2'b01, 2'b00);
    chk({30'h0, pin_override_a, pin_override_b}, 32'h0);
    // status: top from compare A, dual class, no overrides, both levels high
    rd(OFS_STATUS, 32'h123);
    @(posedge pclk);
    $display("test toggle modes done");
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
